// *** src/wwdt_cnt_if.sv ***
/*
 Link between the watchdog control logic and its counter chain.
 Assumes both ends run on the same internal RC clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface wwdt_cnt_if;
    logic        clr;
    logic        run;
    logic [3:0]  tap_sel;
    logic [23:0] tick_len;
    logic [7:0]  count;
    logic [15:0] ps;
    logic        expire;
    modport ctrl (output clr, run, tap_sel, tick_len,
                  input count, ps, expire);
    modport cnt  (input clr, run, tap_sel, tick_len,
                  output count, ps, expire);
endinterface
`default_nettype wire

// *** src/wwdt_counter.sv ***
/*
 Counter chain: tick divider, 8-bit watchdog counter and 16-bit
 postscaler with a selectable expiry tap. Assumes the control side
 holds tick_len at one or more and pulses clr for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module wwdt_counter (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    wwdt_cnt_if.cnt    cif
);
    typedef struct packed {
        logic [23:0] div;
        logic [7:0]  cnt;
        logic [15:0] ps;
        logic        expire;
    } wwdt_cnt_state_t;

    wwdt_cnt_state_t state_ff;
    wwdt_cnt_state_t nxt_state;
    logic [16:0]     tap_span;
    logic [15:0]     tap_mask;

    always_comb begin
        tap_span = (17'h0_0001 << cif.tap_sel) - 17'h0_0001;
        tap_mask = tap_span[15:0];
        nxt_state = state_ff;
        nxt_state.expire = 1'b0;
        if (cif.clr || !cif.run) begin
            nxt_state.div = 24'h00_0000;
            nxt_state.cnt = 8'h00;
            nxt_state.ps  = 16'h0000;
        end else if (state_ff.div >= cif.tick_len - 24'h00_0001) begin
            nxt_state.div = 24'h00_0000;
            nxt_state.cnt = state_ff.cnt + 8'h01;
            if (state_ff.cnt == 8'hff) begin
                if (state_ff.ps == tap_mask) begin
                    nxt_state.expire = 1'b1;
                    nxt_state.ps = 16'h0000;
                end else begin
                    nxt_state.ps = state_ff.ps + 16'h0001;
                end
            end
        end else begin
            nxt_state.div = state_ff.div + 24'h00_0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cif.count  = state_ff.cnt;
    assign cif.ps     = state_ff.ps;
    assign cif.expire = state_ff.expire;

    chk_clear_zeroes: assert property (@(posedge ref_clk) disable iff (rst)
        cif.clr |=> (cif.count == 8'h00) && (cif.ps == 16'h0000))
        else $error("counter not zero after clear");

    chk_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
        (cif.run && !cif.clr && $past(cif.run) && !$past(cif.clr)
        && $changed(cif.count)) |->
        ($past(state_ff.div) == $past(cif.tick_len) - 24'h00_0001))
        else $error("counter stepped off the tick boundary");

    chk_tap_expiry: assert property (@(posedge ref_clk) disable iff (rst)
        cif.expire |-> ($past(state_ff.ps) == $past(tap_mask)) &&
        ($past(state_ff.cnt) == 8'hff))
        else $error("expiry not at selected postscaler tap");
endmodule // wwdt_counter
`default_nettype wire

// *** src/wwdt_pkg.sv ***
/*
 Shared constants of the windowed watchdog: register map, field layout,
 reset values and timing counts. Assumes a 250 MHz internal RC clock.
*/
package wwdt_pkg;
    localparam int          CLK_FREQ_HZ    = 250_000_000;
    localparam int          BASE_PERIOD_MS = 4;
    localparam int          BASE_CYCLES    = BASE_PERIOD_MS * (CLK_FREQ_HZ / 1000);
    localparam int          COUNT_STEPS    = 256;
    localparam int          TRIM_SCALE     = 64;
    localparam int          TRIM_W         = 6;
    localparam int          TAP_W          = 4;
    localparam int          PS_W           = 16;
    localparam int          CNT_W          = 8;
    localparam int          DIV_W          = 24;
    localparam logic [7:0]  WINDOW_THRESH  = 8'hc0;

    localparam logic [7:0]  ADDR_CONTROL   = 8'h00;
    localparam logic [7:0]  ADDR_CONFIG    = 8'h04;
    localparam logic [7:0]  ADDR_TRIM      = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
    localparam logic [7:0]  ADDR_MASK      = 8'h10;
    localparam logic [7:0]  ADDR_COUNT     = 8'h14;

    localparam int          CTL_SWEN_BIT   = 0;
    localparam int          CTL_WIN_BIT    = 1;
    localparam int          CFG_TAP_LSB    = 0;
    localparam int          CFG_EN_BIT     = 4;
    localparam int          CFG_WMODE_BIT  = 5;
    localparam int          CNT_PS_LSB     = 8;
    localparam int          ST_W           = 2;
    localparam int          ST_TIMEOUT_BIT = 0;
    localparam int          ST_EARLY_BIT   = 1;

    localparam logic [3:0]  CFG_TAP_RESET  = 4'h0;
    localparam logic        CFG_EN_RESET   = 1'b0;
    localparam logic        CFG_WMODE_RST  = 1'b1;
endpackage

// *** src/wwdt_top.sv ***
/*
 Windowed watchdog with APB register access, core event inputs, device
 reset output and a masked interrupt. Assumes the core event inputs and
 the APB master run on ref_clk, the internal RC oscillator clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wwdt_top #(
    parameter int BASE_CYCLES = wwdt_pkg::BASE_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        watchdog_kick_instr,
    input  wire logic        sleep_instr,
    input  wire logic        clock_fail,
    input  wire logic [2:0]  intosc_freq_select,
    output logic             rc_osc_enable,
    output logic             device_reset,
    output logic             expiry_status_flag,
    output logic             sleep_entry_flag,
    output logic             irq
);
    localparam int TICK_BASE = BASE_CYCLES / wwdt_pkg::COUNT_STEPS;

    typedef struct packed {
        logic        sw_en;
        logic [3:0]  tap;
        logic        cfg_en;
        logic        wmode;
        logic [5:0]  trim;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [2:0]  prev_fsel;
        logic        osc_en;
        logic        dev_rst;
        logic        to_flag;
        logic        pd_flag;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } wwdt_state_t;

    wwdt_state_t state_ff;
    wwdt_state_t nxt_state;
    wwdt_cnt_if  cif ();

    logic        active;
    logic        win_open;
    logic        early_kick;
    logic        timeout;
    logic        wr_done;
    logic        rd_load;
    logic        mapped;
    logic [31:0] rd_word;
    logic [1:0]  st_set;
    int          tick_calc;

    wwdt_counter u_counter (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cif     (cif)
    );

    always_comb begin
        tick_calc = TICK_BASE
            + (TICK_BASE / wwdt_pkg::TRIM_SCALE) * $signed(state_ff.trim);
        if (tick_calc < 1) begin
            tick_calc = 1;
        end
    end

    // Configuration enable forces the watchdog on; software can only add.
    assign active   = state_ff.cfg_en | state_ff.sw_en;
    assign win_open = cif.count >= wwdt_pkg::WINDOW_THRESH;
    assign early_kick = watchdog_kick_instr && active && !state_ff.wmode
        && !win_open;
    assign timeout  = cif.expire && active;

    // A frequency select change clears the chain, since the tick would lie.
    assign cif.clr = watchdog_kick_instr | sleep_instr | clock_fail
        | (intosc_freq_select != state_ff.prev_fsel)
        | state_ff.dev_rst;
    assign cif.run = active;
    assign cif.tap_sel = state_ff.tap;
    assign cif.tick_len = tick_calc[23:0];

    // One wait state: data is fetched on the first access edge.
    assign rd_load = psel && penable && !state_ff.pready;
    assign wr_done = psel && penable && state_ff.pready && pwrite;
    assign mapped  = (paddr == wwdt_pkg::ADDR_CONTROL)
        || (paddr == wwdt_pkg::ADDR_CONFIG)
        || (paddr == wwdt_pkg::ADDR_TRIM)
        || (paddr == wwdt_pkg::ADDR_STATUS)
        || (paddr == wwdt_pkg::ADDR_MASK)
        || (paddr == wwdt_pkg::ADDR_COUNT);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            wwdt_pkg::ADDR_CONTROL: begin
                rd_word[wwdt_pkg::CTL_SWEN_BIT] = state_ff.sw_en;
                rd_word[wwdt_pkg::CTL_WIN_BIT]  = win_open;
            end
            wwdt_pkg::ADDR_CONFIG: begin
                rd_word[wwdt_pkg::CFG_TAP_LSB +: wwdt_pkg::TAP_W] =
                    state_ff.tap;
                rd_word[wwdt_pkg::CFG_EN_BIT]    = state_ff.cfg_en;
                rd_word[wwdt_pkg::CFG_WMODE_BIT] = state_ff.wmode;
            end
            wwdt_pkg::ADDR_TRIM: begin
                rd_word[wwdt_pkg::TRIM_W-1:0] = state_ff.trim;
            end
            wwdt_pkg::ADDR_STATUS: begin
                rd_word[wwdt_pkg::ST_W-1:0] = state_ff.status;
            end
            wwdt_pkg::ADDR_MASK: begin
                rd_word[wwdt_pkg::ST_W-1:0] = state_ff.mask;
            end
            wwdt_pkg::ADDR_COUNT: begin
                rd_word[wwdt_pkg::CNT_W-1:0] = cif.count;
                rd_word[wwdt_pkg::CNT_PS_LSB +: wwdt_pkg::PS_W] = cif.ps;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        st_set = 2'b00;
        st_set[wwdt_pkg::ST_TIMEOUT_BIT] = timeout;
        st_set[wwdt_pkg::ST_EARLY_BIT]   = early_kick;
        nxt_state = state_ff;
        nxt_state.prev_fsel = intosc_freq_select;
        nxt_state.osc_en  = active;
        nxt_state.dev_rst = timeout | early_kick;
        nxt_state.pready  = rd_load;
        if (rd_load) begin
            nxt_state.prdata  = mapped ? rd_word : 32'h0000_0000;
            nxt_state.pslverr = !mapped;
        end else begin
            nxt_state.pslverr = 1'b0;
        end
        if (wr_done) begin
            case (paddr)
                wwdt_pkg::ADDR_CONTROL: begin
                    nxt_state.sw_en = pwdata[wwdt_pkg::CTL_SWEN_BIT];
                end
                wwdt_pkg::ADDR_CONFIG: begin
                    nxt_state.tap =
                        pwdata[wwdt_pkg::CFG_TAP_LSB +: wwdt_pkg::TAP_W];
                    nxt_state.cfg_en = pwdata[wwdt_pkg::CFG_EN_BIT];
                    nxt_state.wmode  = pwdata[wwdt_pkg::CFG_WMODE_BIT];
                end
                wwdt_pkg::ADDR_TRIM: begin
                    nxt_state.trim = pwdata[wwdt_pkg::TRIM_W-1:0];
                end
                wwdt_pkg::ADDR_STATUS: begin
                    nxt_state.status = state_ff.status
                        & ~pwdata[wwdt_pkg::ST_W-1:0];
                end
                wwdt_pkg::ADDR_MASK: begin
                    nxt_state.mask = pwdata[wwdt_pkg::ST_W-1:0];
                end
                default: begin
                    nxt_state.mask = state_ff.mask;
                end
            endcase
        end
        // New events win over a same-cycle write-one clear.
        nxt_state.status = nxt_state.status | st_set;
        if (sleep_instr) begin
            nxt_state.pd_flag = 1'b0;
        end
        if (timeout) begin
            nxt_state.to_flag = 1'b0;
        end
        if (watchdog_kick_instr) begin
            nxt_state.to_flag = 1'b1;
            nxt_state.pd_flag = 1'b1;
        end
        nxt_state.irq = |(nxt_state.status & nxt_state.mask);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
            state_ff.tap     <= wwdt_pkg::CFG_TAP_RESET;
            state_ff.cfg_en  <= wwdt_pkg::CFG_EN_RESET;
            state_ff.wmode   <= wwdt_pkg::CFG_WMODE_RST;
            state_ff.to_flag <= 1'b1;
            state_ff.pd_flag <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata             = state_ff.prdata;
    assign pready             = state_ff.pready;
    assign pslverr            = state_ff.pslverr;
    assign rc_osc_enable      = state_ff.osc_en;
    assign device_reset       = state_ff.dev_rst;
    assign expiry_status_flag = state_ff.to_flag;
    assign sleep_entry_flag   = state_ff.pd_flag;
    assign irq                = state_ff.irq;

    sequence s_early_kick;
        watchdog_kick_instr && active && !state_ff.wmode && !win_open;
    endsequence

    sequence s_reset_pulse;
        device_reset ##1 !device_reset;
    endsequence

    chk_osc_follows_en: assert property (@(posedge ref_clk) disable iff (rst)
        active [*2] |-> rc_osc_enable)
        else $error("oscillator off while watchdog active");

    chk_cfg_overrides: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff.cfg_en && !state_ff.sw_en) |=> rc_osc_enable)
        else $error("configuration enable did not run watchdog");

    chk_early_kick_rst: assert property (@(posedge ref_clk) disable iff (rst)
        s_early_kick |=> s_reset_pulse or (device_reset ##1 device_reset))
        else $error("premature kick did not reset");

    chk_expiry_reset: assert property (@(posedge ref_clk) disable iff (rst)
        cif.expire && active |=> device_reset &&
        state_ff.status[wwdt_pkg::ST_TIMEOUT_BIT] && !expiry_status_flag)
        else $error("expiry did not reset device");

    chk_window_read: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_load && paddr == wwdt_pkg::ADDR_CONTROL) |=>
        pready && (prdata[wwdt_pkg::CTL_WIN_BIT] ==
        ($past(cif.count) >= wwdt_pkg::WINDOW_THRESH)))
        else $error("window flag read wrong");

    chk_control_write: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_done && paddr == wwdt_pkg::ADDR_CONTROL) |=>
        state_ff.sw_en == $past(pwdata[wwdt_pkg::CTL_SWEN_BIT]))
        else $error("software enable not written");

    chk_kick_flags: assert property (@(posedge ref_clk) disable iff (rst)
        watchdog_kick_instr |=> expiry_status_flag && sleep_entry_flag
        && cif.count == 8'h00 && cif.ps == 16'h0000)
        else $error("kick did not set flags and zero chain");

    chk_fsel_clear: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(intosc_freq_select) |=> cif.count == 8'h00)
        else $error("frequency select change did not clear");

    chk_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
        |(state_ff.status & state_ff.mask) |-> irq)
        else $error("interrupt low with unmasked status");
endmodule // wwdt_top
`default_nettype wire

// *** verif/windowed_watchdog_timer_tb.sv ***
/*
 Self-checking bench of the windowed watchdog over APB and core events.
 Assumes a short base period so that every expiry stays within 1030 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb;
    // A base of 256 cycles gives one counter step per clock.
    localparam int BASE = 256;
    logic        ref_clk;
    logic        rst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        kick;
    logic        sleep_instr;
    logic        clock_fail;
    logic [2:0]  freq_sel;
    logic        rc_osc_enable;
    logic        device_reset;
    logic        expiry_flag;
    logic        sleep_flag;
    logic        irq;
    logic        last_err;
    int          n_mismatch;
    int          total_checks;
    int          cycles = 0;

    wwdt_top #(.BASE_CYCLES(BASE)) uut (
        .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watchdog_kick_instr(kick), .sleep_instr(sleep_instr),
        .clock_fail(clock_fail), .intosc_freq_select(freq_sel),
        .rc_osc_enable(rc_osc_enable), .device_reset(device_reset),
        .expiry_status_flag(expiry_flag), .sleep_entry_flag(sleep_flag),
        .irq(irq));
    wwdt_core_model core (
        .ref_clk(ref_clk), .watchdog_kick_instr(kick),
        .sleep_instr(sleep_instr), .clock_fail(clock_fail),
        .intosc_freq_select(freq_sel));

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The request stands until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'h1;
        @(posedge ref_clk);
        while (pready !== 1'h1) @(posedge ref_clk);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        logic [31:0] d;
        apb(1'h0, a, 32'h0, d);
        check(what, d, exp);
    endtask

    task automatic t_reset;
        rd_chk(wwdt_pkg::ADDR_CONFIG, 32'h20, "cfg_reset");
        rd_chk(wwdt_pkg::ADDR_CONTROL, 32'h0, "ctl_reset");
        rd_chk(wwdt_pkg::ADDR_COUNT, 32'h0, "count_idle");
        rd_chk(8'h18, 32'h0, "unmapped");
        check("unmapped_err", 32'(last_err), 32'h1);
        check("osc_idle", 32'(rc_osc_enable), 32'h0);
        check("flags_reset", {expiry_flag, sleep_flag, irq}, 32'h6);
        $display("t_reset done");
    endtask

    task automatic t_enable;
        logic [31:0] d;
        apb(1'h1, wwdt_pkg::ADDR_CONTROL, 32'h3, d);
        rd_chk(wwdt_pkg::ADDR_CONTROL, 32'h1, "ctl_rw");
        check("osc_on", 32'(rc_osc_enable), 32'h1);
        apb(1'h1, wwdt_pkg::ADDR_TRIM, 32'h3f, d);
        rd_chk(wwdt_pkg::ADDR_TRIM, 32'h3f, "trim_rw");
        apb(1'h1, wwdt_pkg::ADDR_TRIM, 32'h0, d);
        apb(1'h1, wwdt_pkg::ADDR_CONFIG, 32'h30, d);
        apb(1'h1, wwdt_pkg::ADDR_CONTROL, 32'h0, d);
        apb(1'h0, wwdt_pkg::ADDR_COUNT, 32'h0, d);
        check("cfg_overrides", 32'(rc_osc_enable), 32'h1);
        apb(1'h1, wwdt_pkg::ADDR_CONFIG, 32'h20, d);
        rd_chk(wwdt_pkg::ADDR_COUNT, 32'h0, "count_off");
        check("osc_off", 32'(rc_osc_enable), 32'h0);
        apb(1'h1, wwdt_pkg::ADDR_CONTROL, 32'h1, d);
        $display("t_enable done");
    endtask

    // Sleep, clock failure, frequency change and kick each clear the chain.
    task automatic t_events;
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            core.issue((i + 1) % 4, 100);
            @(negedge ref_clk);
            apb(1'h0, wwdt_pkg::ADDR_COUNT, 32'h0, d);
            check("count_cleared", 32'(d < 32'h8), 32'h1);
            if (i == 0) begin
                check("sleep_flag", 32'(sleep_flag), 32'h0);
            end
        end
        check("kick_flags", {expiry_flag, sleep_flag}, 32'h3);
        $display("t_events done");
    endtask

    task automatic t_timeout;
        logic [31:0] d;
        int          n;
        apb(1'h1, wwdt_pkg::ADDR_MASK, 32'h1, d);
        for (int tap = 0; tap < 3; tap++) begin
            apb(1'h1, wwdt_pkg::ADDR_CONFIG, 32'h20 | tap, d);
            core.issue(0, 0);
            n = 0;
            while (device_reset !== 1'h1 && n < 5000) begin
                @(negedge ref_clk);
                n++;
            end
            check("expiry_len", 32'(n >= (BASE << tap) &&
                  n <= (BASE << tap) + 6), 32'h1);
            @(negedge ref_clk);
            check("expiry_flag", {expiry_flag, irq}, 32'h1);
            rd_chk(wwdt_pkg::ADDR_STATUS, 32'h1, "st_timeout");
            apb(1'h1, wwdt_pkg::ADDR_STATUS, 32'h1, d);
            rd_chk(wwdt_pkg::ADDR_STATUS, 32'h0, "st_clear");
            check("irq_clear", 32'(irq), 32'h0);
        end
        $display("t_timeout done");
    endtask

    task automatic t_window;
        logic [31:0] d;
        logic        seen;
        int          n;
        apb(1'h1, wwdt_pkg::ADDR_MASK, 32'h2, d);
        apb(1'h1, wwdt_pkg::ADDR_CONFIG, 32'h0, d);
        core.issue(1, 0);
        rd_chk(wwdt_pkg::ADDR_CONTROL, 32'h1, "win_closed");
        core.issue(0, 0);
        @(negedge ref_clk);
        check("early_reset", {device_reset, irq}, 32'h3);
        rd_chk(wwdt_pkg::ADDR_STATUS, 32'h2, "st_early");
        apb(1'h1, wwdt_pkg::ADDR_STATUS, 32'h2, d);
        d = 32'h0;
        n = 0;
        while (d[1] !== 1'h1 && n < 300) begin
            apb(1'h0, wwdt_pkg::ADDR_CONTROL, 32'h0, d);
            n++;
        end
        apb(1'h0, wwdt_pkg::ADDR_COUNT, 32'h0, d);
        check("win_count", 32'(d[7:0] >= 8'hc0), 32'h1);
        // Software keeps the window here, so no reset may follow.
        core.issue(0, 0);
        seen = 1'h0;
        repeat (4) begin
            @(negedge ref_clk);
            seen = seen | device_reset;
        end
        check("late_kick", 32'(seen), 32'h0);
        rd_chk(wwdt_pkg::ADDR_STATUS, 32'h0, "st_late");
        $display("t_window done");
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    // The whole run needs some 2600 cycles; the ceiling leaves margin.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_mismatch = 0;
        total_checks = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'h0;
        t_reset();
        t_enable();
        t_events();
        t_timeout();
        t_window();
        final_report();
    end
endmodule // windowed_watchdog_timer_tb
`default_nettype wire

// *** verif/wwdt_core_model.sv ***
/*
 Core-side model: issues kick, sleep and clock-failure events as one-cycle
 requests and frequency-select changes as lasting steps. Assumes it shares ref_clk with the block.
*/
`timescale 1ns/1ps
`default_nettype none
module wwdt_core_model (
    input  wire logic       ref_clk,
    output logic            watchdog_kick_instr,
    output logic            sleep_instr,
    output logic            clock_fail,
    output logic      [2:0] intosc_freq_select
);
    initial begin
        watchdog_kick_instr = 1'h0;
        sleep_instr         = 1'h0;
        clock_fail          = 1'h0;
        intosc_freq_select  = 3'h0;
    end
    // Event 0 kick, 1 sleep, 2 clock failure, 3 frequency select change.
    // The delay lets the core answer slowly, as a busy program would.
    task automatic issue(input int ev, input int delay);
        repeat (delay) @(posedge ref_clk);
        @(posedge ref_clk);
        case (ev)
            0: watchdog_kick_instr <= 1'h1;
            1: sleep_instr <= 1'h1;
            2: clock_fail <= 1'h1;
            default: intosc_freq_select <= intosc_freq_select + 3'h1;
        endcase
        @(posedge ref_clk);
        watchdog_kick_instr <= 1'h0;
        sleep_instr <= 1'h0;
        clock_fail <= 1'h0;
    endtask
endmodule // wwdt_core_model
`default_nettype wire
